// ==== verilog/npu_reset_security_powerup.sv ====
// reset, boot security level and q-channel power-up sequencer
// ==========================================================================
// Notes on behaviour
// - refuse soft reset to a higher security level
// - hard reset clears all registers but the synchronisers; soft reset ends by starting a ram clear
// - drain outstanding axi transactions before soft reset
// - privilege strap sampled first cycle after reset
// - security strap sampled first cycle after reset
// - apb access checked against pprot and level
// - own level driven on arprot and awprot
// - power run request raises clock activity hint
// - clock run request starts internal ram clear
// - power accept deasserted last, completing run
// - no quiesce while task runs or queued
`default_nettype none
module npu_reset_security_powerup
  import boot_seq_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 boot_privilege_select,
  input  wire logic                 boot_security_select,
  input  wire logic                 soft_reset_req,
  input  wire sec_level_t           soft_reset_level,
  input  wire logic [TXN_CNT_W-1:0] axi_outstanding,
  input  wire logic                 apb_psel,
  input  wire logic [PROT_W-1:0]    apb_pprot,
  input  wire logic                 task_active,
  input  wire logic                 task_queued,
  input  wire logic                 power_quiesce_request_n,
  input  wire logic                 clock_quiesce_request_n,
  output logic                      soft_reset_refused,
  output logic                      axi_issue_hold,
  output logic                      internal_reset_n,
  output logic                      apb_access_ok,
  output logic [PROT_W-1:0]         axi_arprot,
  output logic [PROT_W-1:0]         axi_awprot,
  output sec_level_t                current_level,
  output qch_out_t                  power_qch,
  output qch_out_t                  clock_qch,
  output logic [RAM_AW-1:0]         ram_clear_addr,
  output logic                      ram_clear_we,
  output logic                      ram_clear_busy
);
  // ==========================================================================
  // synchronisers for straps and q-channel requests (not reset, so the
  // straps are already settled when hard reset lets go)
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  always_ff @(posedge clk) begin
    sync1_r <= {clock_quiesce_request_n, power_quiesce_request_n,
                boot_security_select, boot_privilege_select};
    sync2_r <= sync1_r;
  end
  logic priv_pin_s;
  logic sec_pin_s;
  logic preq_n_s;
  logic creq_n_s;
  assign priv_pin_s = sync2_r[0];
  assign sec_pin_s  = sync2_r[1];
  assign preq_n_s   = sync2_r[2];
  assign creq_n_s   = sync2_r[3];

  // ==========================================================================
  // level capture and soft reset sequence
  typedef enum logic [1:0] {
    SR_BOOT  = 2'b00,
    SR_IDLE  = 2'b01,
    SR_DRAIN = 2'b10,
    SR_RESET = 2'b11
  } sr_state_t;

  sr_state_t               sr_r;
  sr_state_t               sr_nxt;
  sec_level_t              level_r;
  sec_level_t              level_nxt;
  sec_level_t              pend_r;
  sec_level_t              pend_nxt;
  logic [SOFT_CNT_W-1:0]   cnt_r;
  logic [SOFT_CNT_W-1:0]   cnt_nxt;
  logic                    refused_r;
  logic                    refused_nxt;
  logic                    escalates;

  // a request escalates if it asks for secure from non-secure or priv from user
  assign escalates = (level_r.nonsecure && !soft_reset_level.nonsecure) ||
                     (!level_r.privileged && soft_reset_level.privileged);

  always_comb begin
    sr_nxt      = sr_r;
    level_nxt   = level_r;
    pend_nxt    = pend_r;
    cnt_nxt     = cnt_r;
    refused_nxt = 1'b0;
    unique case (sr_r)
      SR_BOOT: begin
        // first edge after release: straps fix the level
        level_nxt.privileged = priv_pin_s;
        level_nxt.nonsecure  = sec_pin_s;
        sr_nxt               = SR_IDLE;
      end
      SR_IDLE: begin
        if (soft_reset_req) begin
          if (escalates) begin
            refused_nxt = 1'b1;
          end else begin
            pend_nxt = soft_reset_level;
            sr_nxt   = SR_DRAIN;
          end
        end
      end
      SR_DRAIN: begin
        if (axi_outstanding == '0) begin
          sr_nxt  = SR_RESET;
          cnt_nxt = SOFT_CNT_W'(SOFT_RST_CYC - 1);
        end
      end
      SR_RESET: begin
        if (cnt_r == '0) begin
          sr_nxt    = SR_IDLE;
          level_nxt = pend_r;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
    endcase
  end

  // everything returns to constants while hard reset is low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sr_r      <= SR_BOOT;
      level_r   <= LEVEL_RST;
      pend_r    <= LEVEL_RST;
      cnt_r     <= '0;
      refused_r <= 1'b0;
    end else begin
      sr_r      <= sr_nxt;
      level_r   <= level_nxt;
      pend_r    <= pend_nxt;
      cnt_r     <= cnt_nxt;
      refused_r <= refused_nxt;
    end
  end

  assign soft_reset_refused = refused_r;
  assign axi_issue_hold     = (sr_r == SR_DRAIN) || (sr_r == SR_RESET);
  assign internal_reset_n   = (sr_r != SR_RESET);
  assign current_level      = level_r;

  // ==========================================================================
  // apb check and axi protection
  always_comb begin
    apb_access_ok = apb_psel &&
                    (apb_pprot[PROT_PRIV_BIT] || !level_r.privileged) &&
                    (!apb_pprot[PROT_NS_BIT] || level_r.nonsecure);
  end
  assign axi_arprot = {1'b0, level_r.nonsecure, level_r.privileged};
  assign axi_awprot = {1'b0, level_r.nonsecure, level_r.privileged};

  // ==========================================================================
  // q-channel power-up and quiesce
  typedef enum logic [1:0] {
    Q_STOP  = 2'b00,
    Q_WCLK  = 2'b01,
    Q_CLEAR = 2'b10,
    Q_RUN   = 2'b11
  } q_state_t;

  q_state_t q_r;
  q_state_t q_nxt;
  logic     cact_r;
  logic     cact_nxt;
  logic     cacc_n_r;
  logic     cacc_n_nxt;
  logic     clr_start;
  logic     busy;

  assign busy = task_active || task_queued;

  always_comb begin
    q_nxt      = q_r;
    cact_nxt   = cact_r;
    cacc_n_nxt = cacc_n_r;
    clr_start  = 1'b0;
    unique case (q_r)
      Q_STOP: begin
        if (preq_n_s) begin
          q_nxt    = Q_WCLK;
          cact_nxt = 1'b1;
        end
      end
      Q_WCLK: begin
        if (creq_n_s) begin
          q_nxt      = Q_CLEAR;
          cacc_n_nxt = 1'b1;
          clr_start  = 1'b1;
        end
      end
      Q_CLEAR: begin
        if (!ram_clear_busy) begin
          q_nxt = Q_RUN;
        end
      end
      Q_RUN: begin
        cact_nxt = busy || !creq_n_s;
        if (!creq_n_s && !busy) begin
          cacc_n_nxt = 1'b0;
        end else if (creq_n_s) begin
          cacc_n_nxt = 1'b1;
        end
        if (!preq_n_s && !busy) begin
          q_nxt      = Q_STOP;
          cact_nxt   = 1'b0;
        end
      end
    endcase
    if (sr_r == SR_RESET && cnt_r == '0) begin
      clr_start = 1'b1;
    end
  end

  // q-channel state registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_r      <= Q_STOP;
      cact_r   <= 1'b0;
      cacc_n_r <= 1'b0;
    end else begin
      q_r      <= q_nxt;
      cact_r   <= cact_nxt;
      cacc_n_r <= cacc_n_nxt;
    end
  end

  // power accept leaves low only on entering run
  assign power_qch.quiesce_accept_n = (q_r == Q_RUN);
  assign power_qch.quiesce_deny     = (q_r == Q_RUN) && !preq_n_s && busy;
  assign power_qch.activity_hint    = apb_psel || busy;
  assign clock_qch.quiesce_accept_n = cacc_n_r;
  assign clock_qch.quiesce_deny     = (q_r == Q_RUN) && !creq_n_s && busy;
  assign clock_qch.activity_hint    = cact_r;

  ram_clear_engine u_clear (
    .clk      (clk),
    .rstn     (rstn),
    .start    (clr_start),
    .clr_addr (ram_clear_addr),
    .clr_we   (ram_clear_we),
    .clr_busy (ram_clear_busy)
  );

  // ==========================================================================
  // checks
  sequence drain_wait_s;
    (sr_r == SR_DRAIN) && (axi_outstanding != '0);
  endsequence
  sequence drain_done_s;
    (sr_r == SR_DRAIN) && (axi_outstanding == '0);
  endsequence

  no_escalate_a: assert property (@(posedge clk) disable iff (!rstn)
    (sr_r == SR_IDLE) && soft_reset_req && escalates |=> refused_r && (sr_r == SR_IDLE))
    else $error("escalating soft reset not refused");
  drain_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    drain_wait_s |=> sr_r != SR_RESET)
    else $error("internal reset before axi drained");
  drain_go_a: assert property (@(posedge clk) disable iff (!rstn)
    drain_done_s |=> !internal_reset_n [*8] ##1 internal_reset_n)
    else $error("soft reset pulse width wrong");
  boot_priv_a: assert property (@(posedge clk) disable iff (!rstn)
    sr_r == SR_BOOT |=> level_r.privileged == $past(priv_pin_s))
    else $error("privilege strap not captured");
  boot_sec_a: assert property (@(posedge clk) disable iff (!rstn)
    sr_r == SR_BOOT |=> level_r.nonsecure == $past(sec_pin_s))
    else $error("security strap not captured");
  apb_secure_a: assert property (@(posedge clk) disable iff (!rstn)
    apb_psel && apb_pprot[PROT_NS_BIT] && !level_r.nonsecure |-> !apb_access_ok)
    else $error("non-secure access to secure device allowed");
  axi_prot_a: assert property (@(posedge clk) disable iff (!rstn)
    axi_arprot[PROT_NS_BIT] == level_r.nonsecure &&
    axi_awprot[PROT_PRIV_BIT] == level_r.privileged)
    else $error("axi protection does not track level");
  clk_hint_a: assert property (@(posedge clk) disable iff (!rstn)
    (q_r == Q_STOP) && preq_n_s |=> clock_qch.activity_hint)
    else $error("clock hint not raised");
  clr_start_a: assert property (@(posedge clk) disable iff (!rstn)
    (q_r == Q_WCLK) && creq_n_s |=> ram_clear_busy)
    else $error("ram clear not started");
  last_step_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(power_qch.quiesce_accept_n) |-> $past(q_r) == Q_CLEAR && !ram_clear_busy)
    else $error("power accept released early");
  busy_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    (q_r == Q_RUN) && busy |=> q_r == Q_RUN)
    else $error("quiesced while busy");
endmodule : npu_reset_security_powerup
`default_nettype wire

// ==== verilog/boot_seq_pkg.sv ====
// shared types and constants of the reset, boot security and power-up block
`default_nettype none
package boot_seq_pkg;
  // ==========================================================================
  // security and privilege level
  typedef struct packed {
    logic nonsecure;                     // 1 = non-secure, 0 = secure
    logic privileged;                    // 1 = privileged, 0 = user
  } sec_level_t;

  // protection attribute bit positions (same layout on pprot and axprot)
  localparam int unsigned PROT_PRIV_BIT   = 0;
  localparam int unsigned PROT_NS_BIT     = 1;
  localparam int unsigned PROT_INSTR_BIT  = 2;
  localparam int unsigned PROT_W          = 3;

  // level held while hard reset is asserted
  localparam sec_level_t LEVEL_RST        = '{nonsecure: 1'b0, privileged: 1'b0};

  // ==========================================================================
  // q-channel pair as seen at the device (requests in, answers out)
  typedef struct packed {
    logic quiesce_accept_n;
    logic quiesce_deny;
    logic activity_hint;
  } qch_out_t;

  // ==========================================================================
  // timing and memory sizes
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned SOFT_RST_NS     = 64;   // internal reset pulse width
  localparam int unsigned SOFT_RST_CYC    = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SOFT_CNT_W      = 4;
  localparam int unsigned RAM_WORDS       = 16;   // words swept by the clear engine
  localparam int unsigned RAM_AW          = 4;
  localparam int unsigned TXN_CNT_W       = 8;    // outstanding transaction count width
endpackage : boot_seq_pkg
`default_nettype wire

// ==== verilog/ram_clear_engine.sv ====
// sweeps every internal ram word to zero after a start pulse
`default_nettype none
module ram_clear_engine
  import boot_seq_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              start,
  output logic [RAM_AW-1:0]      clr_addr,
  output logic                   clr_we,
  output logic                   clr_busy
);
  // ==========================================================================
  // sweep state
  logic [RAM_AW-1:0] addr_r;
  logic [RAM_AW-1:0] addr_nxt;
  logic              busy_r;
  logic              busy_nxt;
  logic [RAM_AW:0]   run_r;              // busy cycles since the last start
  logic [RAM_AW:0]   run_nxt;

  // walk the index; a start while busy restarts from word zero
  always_comb begin
    addr_nxt = addr_r;
    busy_nxt = busy_r;
    run_nxt  = run_r;
    if (start) begin
      addr_nxt = '0;
      busy_nxt = 1'b1;
      run_nxt  = '0;
    end else if (busy_r) begin
      addr_nxt = addr_r + 1'b1;
      run_nxt  = run_r + 1'b1;
      if (addr_r == RAM_AW'(RAM_WORDS - 1)) begin
        busy_nxt = 1'b0;                 // last word written this cycle
        addr_nxt = '0;
      end
    end
  end

  // register the sweep
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_r <= '0;
      busy_r <= 1'b0;
      run_r  <= '0;
    end else begin
      addr_r <= addr_nxt;
      busy_r <= busy_nxt;
      run_r  <= run_nxt;
    end
  end

  assign clr_addr = addr_r;
  assign clr_we   = busy_r;
  assign clr_busy = busy_r;

  // a sweep lasts exactly RAM_WORDS cycles, counted by run_r
  sweep_len_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(busy_r) |-> run_r == (RAM_AW + 1)'(RAM_WORDS))
    else $error("clear sweep length wrong");
  // the index steps once per busy cycle from word zero
  sweep_addr_a: assert property (@(posedge clk) disable iff (!rstn)
    busy_r |-> run_r[RAM_AW-1:0] == addr_r)
    else $error("clear sweep skipped a word");
endmodule : ram_clear_engine
`default_nettype wire

// ==== tb/qch_ctrl_model.sv ====
// power and clock controller model facing the device q-channels
`default_nettype none
module qch_ctrl_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pwr_hint,
  input  wire logic clk_hint,
  input  wire logic quiesce,
  output logic      preq_n,
  output logic      creq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // requests stay quiesced until powered and out of reset, then step to run
  initial begin
    preq_n = 1'b0;
    creq_n = 1'b0;
    forever begin
      @(posedge clk);
      if (!rstn) begin
        preq_n <= 1'b0;
        creq_n <= 1'b0;
      end else if (quiesce) begin
        preq_n <= 1'b0;
      end else if (!preq_n && pwr_hint) begin
        preq_n <= 1'b1;
      end else if (preq_n && clk_hint) begin
        creq_n <= 1'b1;
      end
    end
  end
endmodule : qch_ctrl_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench of the reset, boot security and power-up sequencer
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, a, e); end end
`define WAITF(c) begin wk = 0; while (!(c) && wk < 300) begin \
  @(posedge clk); #1; wk++; end `CHK(c, 1'b1) end
module tb_top
  import boot_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk, rstn, priv_pin, sec_pin, sreq, psel, t_act, t_que;
  logic             preq_n, creq_n, quiesce, refused, hold, irst_n, ok, busy, we;
  sec_level_t       slevel, level;
  logic [7:0]       outs;
  logic [2:0]       pprot, arprot, awprot;
  logic [3:0]       caddr;
  qch_out_t         pq, cq;
  int               failures, n_compared, wk;

  npu_reset_security_powerup u_npu_reset_security_powerup (
    .clk(clk), .rstn(rstn), .boot_privilege_select(priv_pin),
    .boot_security_select(sec_pin), .soft_reset_req(sreq), .soft_reset_level(slevel),
    .axi_outstanding(outs), .apb_psel(psel), .apb_pprot(pprot), .task_active(t_act),
    .task_queued(t_que), .power_quiesce_request_n(preq_n),
    .clock_quiesce_request_n(creq_n), .soft_reset_refused(refused),
    .axi_issue_hold(hold), .internal_reset_n(irst_n), .apb_access_ok(ok),
    .axi_arprot(arprot), .axi_awprot(awprot), .current_level(level),
    .power_qch(pq), .clock_qch(cq), .ram_clear_addr(caddr), .ram_clear_we(we),
    .ram_clear_busy(busy));

  qch_ctrl_model u_qch_ctrl_model (
    .clk(clk), .rstn(rstn), .pwr_hint(pq.activity_hint), .clk_hint(cq.activity_hint),
    .quiesce(quiesce), .preq_n(preq_n), .creq_n(creq_n));

  // ==========================================================================
  // clock and helpers
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task done(input string s);
    $display("test %s finished", s);
  endtask : done

  // access allowed when caller is at least as privileged and at least as secure
  function automatic logic exp_ok(input sec_level_t l, input logic [2:0] p);
    return (p[0] >= l.privileged) && (p[1] <= l.nonsecure);
  endfunction : exp_ok

  task soft_req(input sec_level_t l);
    @(posedge clk);
    sreq   <= 1'b1;
    slevel <= l;
    @(posedge clk);
    sreq <= 1'b0;
    #1;
  endtask : soft_req

  // ==========================================================================
  // scenarios
  task t_powerup();
    @(posedge clk);
    psel  <= 1'b1;
    pprot <= 3'h1;
    #1;
    `CHK(pq.activity_hint, 1'b1)
    `WAITF(cq.activity_hint)
    `CHK(pq.quiesce_accept_n, 1'b0)
    `WAITF(busy)
    `CHK(we, 1'b1)
    `CHK(caddr, 4'h0)
    `CHK(cq.quiesce_accept_n, 1'b1)
    wk = 0;
    while (busy && wk < 300) begin
      tick(1);
      wk++;
    end
    `CHK(wk, RAM_WORDS)
    `CHK(pq.quiesce_accept_n, 1'b0)
    tick(1);
    `CHK(pq.quiesce_accept_n, 1'b1)
    @(posedge clk);
    psel <= 1'b0;
    done("powerup");
  endtask : t_powerup

  task t_apb(input sec_level_t l);
    for (int p = 0; p < 8; p++) begin
      @(posedge clk);
      psel  <= 1'b1;
      pprot <= p[2:0];
      #1;
      `CHK(ok, exp_ok(l, p[2:0]))
    end
    @(posedge clk);
    psel <= 1'b0;
    done("apb");
  endtask : t_apb

  task t_refuse(input sec_level_t l, input sec_level_t cur);
    soft_req(l);
    wk = 0;
    repeat (4) begin
      if (refused === 1'b1) wk++;
      tick(1);
    end
    `CHK(wk, 1)
    `CHK(hold, 1'b0)
    `CHK(level, cur)
    done("refuse");
  endtask : t_refuse

  task t_drain();
    @(posedge clk);
    outs <= 8'h03;
    soft_req(2'b10);
    `WAITF(hold)
    repeat (10) begin
      tick(1);
      `CHK(irst_n, 1'b1)
    end
    @(posedge clk);
    outs <= 8'h00;
    #1;
    `WAITF(!irst_n)
    wk = 0;
    while (!irst_n && wk < 300) begin
      tick(1);
      wk++;
    end
    `CHK(wk, SOFT_RST_CYC)
    `CHK(level, 2'b10)
    `CHK(arprot, 3'h2)
    `CHK(awprot, 3'h2)
    `CHK(busy, 1'b1)
    `CHK(hold, 1'b0)
    `WAITF(!busy)
    `CHK(we, 1'b0)
    `CHK(caddr, 4'h0)
    done("drain");
  endtask : t_drain

  task t_quiesce();
    @(posedge clk);
    t_act   <= 1'b1;
    quiesce <= 1'b1;
    #1;
    `WAITF(pq.quiesce_deny)
    `CHK(cq.quiesce_deny, 1'b0)
    tick(4);
    `CHK(pq.quiesce_accept_n, 1'b1)
    @(posedge clk);
    t_act <= 1'b0;
    t_que <= 1'b1;
    tick(4);
    `CHK(pq.quiesce_accept_n, 1'b1)
    @(posedge clk);
    t_que <= 1'b0;
    #1;
    `WAITF(!pq.quiesce_accept_n)
    done("quiesce");
  endtask : t_quiesce

  task t_rereset();
    @(posedge clk);
    rstn     <= 1'b0;
    priv_pin <= 1'b1;
    sec_pin  <= 1'b0;
    #1;
    `CHK(level, 2'b00)
    `CHK(arprot, 3'h0)
    `CHK(busy, 1'b0)
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    tick(1);
    `CHK(level, 2'b01)
    `CHK(awprot, 3'h1)
    done("rereset");
  endtask : t_rereset

  task report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    {rstn, sreq, psel, t_act, t_que, quiesce} = '0;
    {priv_pin, sec_pin} = 2'b11;
    {slevel, outs, pprot} = '0;
    failures = 0;
    n_compared = 0;
    repeat (15) @(posedge clk);
    #1;
    `CHK(level, 2'b00)
    `CHK(irst_n, 1'b1)
    @(posedge clk);
    rstn <= 1'b1;
    tick(1);
    `CHK(level, 2'b11)
    `CHK(arprot, 3'h3)
    t_powerup();
    t_apb(2'b11);
    t_refuse(2'b01, 2'b11);
    t_drain();
    t_apb(2'b10);
    t_refuse(2'b11, 2'b10);
    t_refuse(2'b00, 2'b10);
    t_quiesce();
    t_rereset();
    t_apb(2'b01);
    report_and_stop();
  end

  initial begin
    #(5000 * 8);
    failures++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
